/* rtl/uif_map.svh */
// Purpose: Register map and field positions of the USB interrupt enable/force stage
// Assumes: APB byte addresses on a 12-bit window, 32-bit data
// Notes:   Definitions only
`ifndef UIF_MAP_SVH
`define UIF_MAP_SVH

`define UIF_AW          12
`define UIF_OFS_RAW     12'h08C
`define UIF_OFS_ENABLE  12'h090
`define UIF_OFS_FORCE   12'h094
`define UIF_OFS_MASKED  12'h098

`define UIF_NSRC        20
`define UIF_RST_ENABLE  20'h00000
`define UIF_RST_FORCE   20'h00000
`define UIF_STICKY_MASK 20'h2E00F

`define UIF_B_HALT      19
`define UIF_B_ABORT     18
`define UIF_B_DEVICE_FRAME_START_SEEN   17
`define UIF_B_SETUP     16
`define UIF_B_DEV_WAKE  15
`define UIF_B_DEV_SLEEP 14
`define UIF_B_DEV_ATT   13
`define UIF_B_BUSRST    12
`define UIF_B_SUPPLY    11
`define UIF_B_STALL     10
`define UIF_B_CRC       9
`define UIF_B_STUFF     8
`define UIF_B_OVFL      7
`define UIF_B_TMO       6
`define UIF_B_TOGGLE    5
`define UIF_B_BUFF      4
`define UIF_B_TRANS     3
`define UIF_B_HOST_SOF  2
`define UIF_B_HOST_WAKE 1
`define UIF_B_HOST_ATT  0

`endif

/* rtl/uif_pkg.sv */
// Purpose: Types shared by the interrupt enable/force stage
// Assumes: Map header supplies the numbers
// Notes:   Types only
`include "uif_map.svh"
package uif_pkg;
  typedef logic [`UIF_NSRC-1:0] uif_src_t;    // One bit per event source
  typedef logic [31:0]          uif_word_t;   // APB data word
  typedef logic [`UIF_AW-1:0]   uif_addr_t;   // APB byte address
  typedef enum logic {UIF_ST_IDLE, UIF_ST_ANSWER} uif_apb_st_t; // Bus answer phase
endpackage

/* rtl/uif_sticky_bit.sv */
// Purpose: One sticky event flag with set priority over clear
// Assumes: Set and clear are same-clock pulses
// Notes:   Frozen while the clock enable is low
`timescale 1ns/100ps
module uif_sticky_bit (
  input  wire logic clk_i,     // System clock
  input  wire logic reset_i,   // Async reset, high
  input  wire logic clk_en_i,  // Freeze when low
  input  wire logic set_i,     // Event pulse
  input  wire logic clr_i,     // Clear pulse
  output logic      flag_o     // Sticky flag
);
  logic flag_reg;  // Held flag

  // Set wins so an event on the clear cycle is never lost
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (set_i) begin
        flag_reg <= 1'b1;
      end else if (clr_i) begin
        flag_reg <= 1'b0;
      end
    end
  end

  assign flag_o = flag_reg;
endmodule // uif_sticky_bit

/* rtl/uif_irq_top.sv */
// Purpose: USB interrupt sources, enable and force registers, interrupt line
// Assumes: All event inputs come from controller logic on clk_i
// Notes:   APB slave answers with one wait state
`timescale 1ns/100ps
`include "uif_map.svh"
module uif_irq_top
  import uif_pkg::*;
(
  input  wire logic        clk_i,            // 50 MHz system clock
  input  wire logic        reset_i,          // Async reset, high
  input  wire logic        clk_en_i,         // Freeze all state when low
  // APB slave
  input  wire logic        psel_i,           // Select
  input  wire logic        penable_i,        // Access phase
  input  wire logic        pwrite_i,         // Write when high
  input  wire uif_addr_t   paddr_i,          // Byte address
  input  wire uif_word_t   pwdata_i,         // Write data
  input  wire logic [3:0]  pstrb_i,          // Byte lanes
  output logic             pready_o,         // Answer
  output uif_word_t        prdata_o,         // Read data
  output logic             pslverr_o,        // Unmapped address
  // Controller role and summary inputs
  input  wire logic        host_mode_i,      // High in host role
  input  wire logic [31:0] per_endpoint_halt_nak_flags_i, // Per-endpoint halt/NAK
  input  wire logic [31:0] abort_done_flags_i,            // Per-endpoint abort done
  input  wire logic [31:0] buffer_done_flags_i,           // Per-buffer status
  // Controller status flags, mirrored
  input  wire logic        control_packet_received_i, // Setup packet seen
  input  wire logic        bus_reset_i,      // Bus reset flag
  input  wire logic        supply_present_flag_i,     // Supply detected
  input  wire logic        stall_received_i, // Stall handshake seen
  input  wire logic        crc_fault_i,      // CRC error
  input  wire logic        stuffing_fault_i, // Bit stuffing error
  input  wire logic        rx_overflow_i,    // Receive overflow
  input  wire logic        rx_timeout_i,     // Receive timeout
  input  wire logic        toggle_sequence_fault_i,   // Data sequence error
  // Controller events and states
  input  wire logic        device_frame_start_seen_i, // Pulse, frame start in
  input  wire logic        host_frame_sent_i,         // Pulse, frame start out
  input  wire logic        device_wake_from_host_i,   // Pulse, resume received
  input  wire logic        host_remote_wake_i,        // Pulse, device woke host
  input  wire logic        suspended_i,      // Suspend state level
  input  wire logic        connected_i,      // Connection state level
  input  wire logic [1:0]  line_speed_i,     // Detected speed field
  input  wire logic        transaction_finished_i,    // Status flag level
  // Software side effects on the controller status register
  input  wire logic        frame_number_read_i,  // Pulse, frame register read
  input  wire logic        resume_flag_write_i,  // Pulse, resume flag write
  input  wire logic        suspended_flag_write_i, // Pulse, suspended flag write
  input  wire logic        connected_flag_write_i, // Pulse, connected flag write
  input  wire logic        speed_field_write_i,    // Pulse, speed field write
  output logic             irq_o             // Level interrupt
);
  localparam uif_src_t STICKY = `UIF_STICKY_MASK; // Bits held by a flag cell

  uif_apb_st_t st_reg;        // Bus answer phase
  uif_src_t    enable_reg;    // Enable register
  uif_src_t    force_reg;     // Force register
  uif_src_t    raw;           // Raw source vector
  uif_src_t    level_src;     // Level sources
  uif_src_t    set_src;       // Sticky set pulses
  uif_src_t    clr_src;       // Sticky clear pulses
  uif_src_t    masked;        // Enabled or forced
  uif_word_t   rdata_next;    // Read mux
  logic        hit_next;      // Address mapped
  logic        susp_d_reg;    // Previous suspend state
  logic        conn_d_reg;    // Previous connection state
  logic [1:0]  speed_d_reg;   // Previous speed field
  logic        trans_d_reg;   // Previous finished flag
  logic        prev_ok_reg;   // History valid after reset
  logic        pready_reg;    // Answer flop
  logic        pslverr_reg;   // Error flop
  uif_word_t   prdata_reg;    // Read data flop
  logic        irq_reg;       // Interrupt flop
  logic        acc;           // Access phase present
  logic        done;          // Transfer completes this edge
  logic        wr_en;         // Write to enable
  logic        wr_force;      // Write to force
  logic        wr_raw;        // Write-one-clear on raw

  // Byte-lane merge of a write into a 20-bit register
  function automatic uif_src_t lane_merge(uif_src_t old, uif_word_t wd, logic [3:0] st);
    uif_word_t m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m[`UIF_NSRC-1:0]) | (wd[`UIF_NSRC-1:0] & m[`UIF_NSRC-1:0]);
  endfunction

  // Address hit check used by both read and write decode
  function automatic logic is_addr(uif_addr_t a, uif_addr_t ofs);
    return a == ofs;
  endfunction

  assign acc      = psel_i && penable_i;
  assign done     = acc && pready_reg;
  assign wr_en    = done && pwrite_i && is_addr(paddr_i, `UIF_OFS_ENABLE);
  assign wr_force = done && pwrite_i && is_addr(paddr_i, `UIF_OFS_FORCE);
  assign wr_raw   = done && pwrite_i && is_addr(paddr_i, `UIF_OFS_RAW);

  // Summary and mirrored level sources
  always_comb begin
    level_src                  = '0;
    level_src[`UIF_B_HALT]     = |per_endpoint_halt_nak_flags_i;
    level_src[`UIF_B_ABORT]    = |abort_done_flags_i;
    level_src[`UIF_B_BUFF]     = |buffer_done_flags_i;
    level_src[`UIF_B_SETUP]    = control_packet_received_i;
    level_src[`UIF_B_BUSRST]   = bus_reset_i;
    level_src[`UIF_B_SUPPLY]   = supply_present_flag_i;
    level_src[`UIF_B_STALL]    = stall_received_i;
    level_src[`UIF_B_CRC]      = crc_fault_i;
    level_src[`UIF_B_STUFF]    = stuffing_fault_i;
    level_src[`UIF_B_OVFL]     = rx_overflow_i;
    level_src[`UIF_B_TMO]      = rx_timeout_i;
    level_src[`UIF_B_TOGGLE]   = toggle_sequence_fault_i;
  end

  // Event pulses, gated by role except the finished edge; change events need valid history
  always_comb begin
    set_src = '0;
    set_src[`UIF_B_DEVICE_FRAME_START_SEEN]   = !host_mode_i && device_frame_start_seen_i;
    set_src[`UIF_B_DEV_WAKE]  = !host_mode_i && device_wake_from_host_i;
    set_src[`UIF_B_DEV_SLEEP] = !host_mode_i && prev_ok_reg
                                && (suspended_i != susp_d_reg);
    set_src[`UIF_B_DEV_ATT]   = !host_mode_i && prev_ok_reg
                                && (connected_i != conn_d_reg);
    set_src[`UIF_B_TRANS]     = prev_ok_reg && transaction_finished_i
                                && !trans_d_reg;
    set_src[`UIF_B_HOST_SOF]  = host_mode_i && host_frame_sent_i;
    set_src[`UIF_B_HOST_WAKE] = host_mode_i && host_remote_wake_i;
    set_src[`UIF_B_HOST_ATT]  = host_mode_i && prev_ok_reg
                                && (line_speed_i != speed_d_reg);
  end

  // Software clear pulses for the sticky bits
  always_comb begin
    clr_src = '0;
    clr_src[`UIF_B_DEVICE_FRAME_START_SEEN]   = frame_number_read_i;
    clr_src[`UIF_B_DEV_WAKE]  = resume_flag_write_i;
    clr_src[`UIF_B_DEV_SLEEP] = suspended_flag_write_i;
    clr_src[`UIF_B_DEV_ATT]   = connected_flag_write_i;
    clr_src[`UIF_B_TRANS]     = wr_raw && pstrb_i[0] && pwdata_i[`UIF_B_TRANS];
    clr_src[`UIF_B_HOST_SOF]  = frame_number_read_i;
    clr_src[`UIF_B_HOST_WAKE] = resume_flag_write_i;
    clr_src[`UIF_B_HOST_ATT]  = speed_field_write_i;
  end

  // One flag cell per sticky bit, plain wire for level bits
  genvar gi;
  generate
    for (gi = 0; gi < `UIF_NSRC; gi = gi + 1) begin : g_src
      if (STICKY[gi]) begin : g_stk
        uif_sticky_bit u_flag (
          .clk_i    (clk_i),
          .reset_i  (reset_i),
          .clk_en_i (clk_en_i),
          .set_i    (set_src[gi]),
          .clr_i    (clr_src[gi]),
          .flag_o   (raw[gi])
        );
      end else begin : g_lvl
        assign raw[gi] = level_src[gi];
      end
    end
  endgenerate

  // Enable gates the raw source, force asserts regardless
  assign masked = (raw & enable_reg) | force_reg;

  // History of levels for change detection
  // Reset values are constants; first enabled edge loads real history
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      susp_d_reg  <= 1'b0;
      conn_d_reg  <= 1'b0;
      speed_d_reg <= 2'h0;
      trans_d_reg <= 1'b0;
      prev_ok_reg <= 1'b0;
    end else if (clk_en_i) begin
      susp_d_reg  <= suspended_i;
      conn_d_reg  <= connected_i;
      speed_d_reg <= line_speed_i;
      trans_d_reg <= transaction_finished_i;
      prev_ok_reg <= 1'b1;
    end
  end

  // Enable and force registers, byte-lane writes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      enable_reg <= `UIF_RST_ENABLE;
      force_reg  <= `UIF_RST_FORCE;
    end else if (clk_en_i) begin
      if (wr_en) begin
        enable_reg <= lane_merge(enable_reg, pwdata_i, pstrb_i);
      end
      if (wr_force) begin
        force_reg <= lane_merge(force_reg, pwdata_i, pstrb_i);
      end
    end
  end

  // Read mux; reserved upper bits read zero
  always_comb begin
    rdata_next = '0;
    hit_next   = 1'b1;
    if (is_addr(paddr_i, `UIF_OFS_RAW)) begin
      rdata_next[`UIF_NSRC-1:0] = raw;
    end else if (is_addr(paddr_i, `UIF_OFS_ENABLE)) begin
      rdata_next[`UIF_NSRC-1:0] = enable_reg;
    end else if (is_addr(paddr_i, `UIF_OFS_FORCE)) begin
      rdata_next[`UIF_NSRC-1:0] = force_reg;
    end else if (is_addr(paddr_i, `UIF_OFS_MASKED)) begin
      rdata_next[`UIF_NSRC-1:0] = masked;
    end else begin
      hit_next = 1'b0;
    end
  end

  // APB answer: one wait state keeps read data a flop output
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg      <= UIF_ST_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else if (clk_en_i) begin
      case (st_reg)
        UIF_ST_IDLE: begin
          if (acc) begin
            st_reg      <= UIF_ST_ANSWER;
            pready_reg  <= 1'b1;
            pslverr_reg <= !hit_next;
            prdata_reg  <= pwrite_i ? '0 : rdata_next;
          end
        end
        UIF_ST_ANSWER: begin
          // Transfer ends here; drop the answer
          st_reg      <= UIF_ST_IDLE;
          pready_reg  <= 1'b0;
          pslverr_reg <= 1'b0;
          prdata_reg  <= '0;
        end
        default: begin
          st_reg     <= UIF_ST_IDLE;
          pready_reg <= 1'b0;
        end
      endcase
    end
  end

  // Interrupt line, one flop after the masked status
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else if (clk_en_i) begin
      irq_reg <= |masked;
    end
  end

  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign prdata_o  = prdata_reg;
  assign irq_o     = irq_reg;

  // Checks on enabled edges only, since state freezes otherwise
  default clocking cb @(posedge clk_i iff clk_en_i);
  endclocking
  default disable iff (reset_i);

  sequence s_frame_read;
    frame_number_read_i && !set_src[`UIF_B_DEVICE_FRAME_START_SEEN];
  endsequence
  sequence s_enable_wr;
    wr_en && (pstrb_i == 4'hF);
  endsequence

  a_halt_summary: assert property (
    raw[`UIF_B_HALT] == |per_endpoint_halt_nak_flags_i)
    else $error("halt summary wrong");
  a_abort_summary: assert property (
    raw[`UIF_B_ABORT] == |abort_done_flags_i)
    else $error("abort summary wrong");
  a_device_frame_start_seen_flag: assert property (
    set_src[`UIF_B_DEVICE_FRAME_START_SEEN] |=> raw[`UIF_B_DEVICE_FRAME_START_SEEN])
    else $error("frame start flag not set");
  a_device_frame_start_seen_clear: assert property (
    s_frame_read |=> !raw[`UIF_B_DEVICE_FRAME_START_SEEN])
    else $error("frame read did not clear");
  a_dev_wake_flag: assert property (
    (!host_mode_i && device_wake_from_host_i) |=> raw[`UIF_B_DEV_WAKE])
    else $error("wake flag not set");
  a_sleep_change: assert property (
    (!host_mode_i && $changed(suspended_i)) |=> raw[`UIF_B_DEV_SLEEP])
    else $error("sleep change missed");
  a_attach_change: assert property (
    (!host_mode_i && $changed(connected_i)) |=> raw[`UIF_B_DEV_ATT])
    else $error("attach change missed");
  a_buffer_summary: assert property (
    raw[`UIF_B_BUFF] == |buffer_done_flags_i)
    else $error("buffer summary wrong");
  a_trans_edge: assert property (
    $rose(transaction_finished_i) |=> raw[`UIF_B_TRANS])
    else $error("finished edge missed");
  a_host_sof_flag: assert property (
    (host_mode_i && host_frame_sent_i) |=> raw[`UIF_B_HOST_SOF])
    else $error("host frame flag not set");
  a_host_wake_flag: assert property (
    (host_mode_i && host_remote_wake_i) |=> raw[`UIF_B_HOST_WAKE])
    else $error("host wake flag not set");
  a_speed_change: assert property (
    (host_mode_i && $changed(line_speed_i)) |=> raw[`UIF_B_HOST_ATT])
    else $error("speed change missed");
  a_force_irq: assert property (
    (|force_reg) |=> irq_o)
    else $error("forced source gave no interrupt");
  a_mask_irq: assert property (
    (masked == '0) |=> !irq_o)
    else $error("interrupt without source");
  a_mirror_flag: assert property (
    raw[`UIF_B_CRC] == crc_fault_i && raw[`UIF_B_SETUP] == control_packet_received_i)
    else $error("mirror flag wrong");
  a_enable_write: assert property (
    s_enable_wr |=> enable_reg == $past(pwdata_i[`UIF_NSRC-1:0]))
    else $error("enable write lost");
  a_reserved_zero: assert property (
    pready_o |-> prdata_o[31:`UIF_NSRC] == '0)
    else $error("reserved bits not zero");

  // Bit 3 write-one-clear, unless a new edge lands on the same cycle
  sequence s_trans_clear;
    clr_src[`UIF_B_TRANS] && !set_src[`UIF_B_TRANS];
  endsequence

  a_trans_clear: assert property (
    s_trans_clear |=> !raw[`UIF_B_TRANS])
    else $error("finished flag not cleared");
  a_sof_set_wins: assert property (
    (set_src[`UIF_B_DEVICE_FRAME_START_SEEN] && frame_number_read_i) |=> raw[`UIF_B_DEVICE_FRAME_START_SEEN])
    else $error("frame start lost on clear");
  a_dev_role_gate: assert property (
    (host_mode_i && !raw[`UIF_B_DEVICE_FRAME_START_SEEN]) |=> !raw[`UIF_B_DEVICE_FRAME_START_SEEN])
    else $error("device frame flag set in host role");
  a_host_role_gate: assert property (
    (!host_mode_i && !raw[`UIF_B_HOST_SOF]) |=> !raw[`UIF_B_HOST_SOF])
    else $error("host frame flag set in device role");
  a_speed_clear: assert property (
    (speed_field_write_i && !set_src[`UIF_B_HOST_ATT]) |=> !raw[`UIF_B_HOST_ATT])
    else $error("speed write did not clear");
  a_force_write: assert property (
    (wr_force && (pstrb_i == 4'hF)) |=> force_reg == $past(pwdata_i[`UIF_NSRC-1:0]))
    else $error("force write lost");
  a_apb_wait: assert property (
    (acc && !pready_o) |=> pready_o)
    else $error("answer not after one wait state");
endmodule // uif_irq_top

/* bench/uif_ctrl_model.sv */
// Purpose: Controller-side source of event strobes and status-clear strobes
// Assumes: Caller enters fire just after a rising edge of clk_i
// Notes:   Strobes last one cycle, since a held strobe would set a flag again
`timescale 1ns/100ps
module uif_ctrl_model (
  input  wire logic       clk_i,   // System clock
  output logic      [8:0] pulse_o  // Strobes, one bit per kind
);
  // Quiet from time zero so no flag is set before the bench asks
  initial pulse_o = 9'h000;

  // One strobe, high for exactly one clock cycle
  task automatic fire(input int k);
    pulse_o[k] <= 1'b1;
    @(posedge clk_i);
    pulse_o <= 9'h000;
  endtask
endmodule // uif_ctrl_model

/* bench/testbench.sv */
// Purpose: Self-checking bench for the interrupt enable/force stage
// Assumes: APB slave answers within 20 cycles
// Notes:   Strobe order 0 dev frame, 1 host frame, 2 dev wake, 3 host wake,
//          4 frame read, 5 resume write, 6 sleep write, 7 attach write, 8 speed write
`timescale 1ns/100ps
`include "uif_map.svh"
module testbench;
  import uif_pkg::*;
  logic        clk_i = 1'b0, reset_i = 1'b1;     // Clock and reset
  logic        psel = 1'b0, penable = 1'b0;      // APB request
  logic        pwrite = 1'b0;                    // APB direction
  uif_addr_t   paddr = '0;                       // APB address
  uif_word_t   pwdata = '0, prdata;              // APB data
  logic        pready, pslverr, irq;             // Design answers
  logic        host_mode = 1'b0, susp = 1'b0;    // Role and sleep level
  logic        conn = 1'b0, trans = 1'b0;        // Attach and done levels
  logic [1:0]  speed = 2'b00;                    // Line speed level
  logic [31:0] halt = '0, abrt = '0, buff = '0;  // Per-unit flag vectors
  logic [8:0]  mir = '0;                         // Mirrored flags, 8 is setup
  logic [8:0]  pulse;                            // Strobes from the model
  logic        clk_en = 1'b1;                    // Clock enable
  logic [3:0]  strb = 4'hF;                      // Byte lanes
  int          mismatches = 0, n_compared = 0;   // Counters
  int          cyc = 0;                          // Cycle count for timeout

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  uif_ctrl_model ctl (.clk_i(clk_i), .pulse_o(pulse));

  uif_irq_top uut (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(strb), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .host_mode_i(host_mode),
    .per_endpoint_halt_nak_flags_i(halt), .abort_done_flags_i(abrt),
    .buffer_done_flags_i(buff), .control_packet_received_i(mir[8]),
    .bus_reset_i(mir[7]), .supply_present_flag_i(mir[6]), .stall_received_i(mir[5]),
    .crc_fault_i(mir[4]), .stuffing_fault_i(mir[3]), .rx_overflow_i(mir[2]),
    .rx_timeout_i(mir[1]), .toggle_sequence_fault_i(mir[0]),
    .device_frame_start_seen_i(pulse[0]), .host_frame_sent_i(pulse[1]),
    .device_wake_from_host_i(pulse[2]), .host_remote_wake_i(pulse[3]),
    .suspended_i(susp), .connected_i(conn), .line_speed_i(speed),
    .transaction_finished_i(trans), .frame_number_read_i(pulse[4]),
    .resume_flag_write_i(pulse[5]), .suspended_flag_write_i(pulse[6]),
    .connected_flag_write_i(pulse[7]), .speed_field_write_i(pulse[8]),
    .irq_o(irq));

  // Verdict, reached from the main sequence or the timeout
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Word compare
  task automatic chk_w(input uif_word_t got, input uif_word_t exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  // Bit compare
  task automatic chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, then lets an edge pass before returning
  task automatic apb(input logic wr, input uif_addr_t a, input uif_word_t d,
                     output uif_word_t q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk_b(1'b0, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input uif_addr_t a, input uif_word_t d);
    uif_word_t q;
    logic      e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input uif_addr_t a, input uif_word_t exp);
    uif_word_t q;
    logic      e;
    apb(1'b0, a, '0, q, e);
    chk_w(q, exp);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Reset values, writable width, force, unmapped access
  task automatic t_regs();
    uif_word_t q;
    logic      e;
    rd_chk(`UIF_OFS_ENABLE, 32'h00000000);
    rd_chk(`UIF_OFS_FORCE, 32'h00000000);
    wr(`UIF_OFS_FORCE, 32'hFFFFFFFF);
    rd_chk(`UIF_OFS_FORCE, 32'h000FFFFF);
    rd_chk(`UIF_OFS_MASKED, 32'h000FFFFF);
    chk_b(irq, 1'b1);
    wr(`UIF_OFS_FORCE, 32'h00000000);
    gap(2);
    chk_b(irq, 1'b0);
    wr(`UIF_OFS_ENABLE, 32'hFFFFFFFF);
    rd_chk(`UIF_OFS_ENABLE, 32'h000FFFFF);
    apb(1'b0, 12'h0A0, '0, q, e);
    chk_b(e, 1'b1);
    chk_w(q, 32'h00000000);
  endtask

  // Each controller flag shows at its own bit and raises the line
  task automatic t_mirror();
    for (int i = 0; i < 9; i++) begin
      mir <= 9'(1 << i);
      gap(2);
      rd_chk(`UIF_OFS_RAW, 32'(1 << ((i == 8) ? `UIF_B_SETUP : i + 5)));
      chk_b(irq, 1'b1);
      mir <= '0;
      gap(1);
    end
  endtask

  // Summary stays up until every contributing flag is gone
  task automatic sum_chk(input int j, input int b);
    logic [31:0] v[3];
    v = '{32'h80000001, 32'h80000000, 32'h00000000};
    for (int s = 0; s < 3; s++) begin
      if (j == 0) halt <= v[s];
      else if (j == 1) abrt <= v[s];
      else buff <= v[s];
      gap(2);
      rd_chk(`UIF_OFS_RAW, (s < 2) ? 32'(1 << b) : 32'h0);
    end
  endtask

  // Strobe event: refused in the other role, set in its own, cleared by c
  task automatic ev_chk(input int s, input int b, input int c, input logic h);
    host_mode <= ~h;
    gap(1);
    ctl.fire(s);
    rd_chk(`UIF_OFS_RAW, 32'h0);
    host_mode <= h;
    gap(1);
    ctl.fire(s);
    rd_chk(`UIF_OFS_RAW, 32'(1 << b));
    ctl.fire(c);
    rd_chk(`UIF_OFS_RAW, 32'h0);
  endtask

  // Level change event: 0 sleep, 1 attach, 2 line speed; refused in the other role first
  task automatic chg_chk(input int k, input int b, input int c, input logic h);
    for (int p = 0; p < 2; p++) begin
      host_mode <= p ? h : ~h;
      gap(1);
      if (k == 0) susp <= ~susp;
      else if (k == 1) conn <= ~conn;
      else speed <= speed + 2'd1;
      gap(2);
      rd_chk(`UIF_OFS_RAW, p ? 32'(1 << b) : 32'h0);
    end
    ctl.fire(c);
    rd_chk(`UIF_OFS_RAW, 32'h0);
  endtask

  // Rising edge of the done level sets bit 3; a held level does not re-set it
  task automatic t_trans();
    trans <= 1'b1;
    gap(2);
    rd_chk(`UIF_OFS_RAW, 32'h00000008);
    wr(`UIF_OFS_RAW, 32'h00000008);
    rd_chk(`UIF_OFS_RAW, 32'h00000000);
    trans <= 1'b0;
    gap(2);
    rd_chk(`UIF_OFS_RAW, 32'h00000000);
  endtask

  // Masking reaches the masked word and the line, forcing reaches the masked word
  task automatic t_mask();
    wr(`UIF_OFS_ENABLE, 32'h00000000);
    mir <= 9'h100;
    gap(2);
    chk_b(irq, 1'b0);
    rd_chk(`UIF_OFS_MASKED, 32'h00000000);
    wr(`UIF_OFS_ENABLE, 32'h00010000);
    gap(2);
    chk_b(irq, 1'b1);
    wr(`UIF_OFS_FORCE, 32'h00000001);
    rd_chk(`UIF_OFS_MASKED, 32'h00010001);
    mir <= '0;
    wr(`UIF_OFS_FORCE, 32'h00000000);
    gap(2);
    chk_b(irq, 1'b0);
  endtask

  // Byte lanes, a frozen clock that drops a strobe, and a reset in mid-run
  task automatic t_lanes();
    strb <= 4'h4;
    wr(`UIF_OFS_ENABLE, 32'hFFFFFFFF);
    strb <= 4'hF;
    rd_chk(`UIF_OFS_ENABLE, 32'h000F0000);
    clk_en <= 1'b0;
    ctl.fire(1);
    clk_en <= 1'b1;
    rd_chk(`UIF_OFS_RAW, 32'h00000000);
    wr(`UIF_OFS_FORCE, 32'h00000001);
    reset_i <= 1'b1;
    gap(2);
    reset_i <= 1'b0;
    gap(1);
    rd_chk(`UIF_OFS_FORCE, 32'h00000000);
    rd_chk(`UIF_OFS_ENABLE, 32'h00000000);
    rd_chk(`UIF_OFS_RAW, 32'h00000000);
    chk_b(irq, 1'b0);
  endtask

  // Hang guard, well beyond the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    gap(1);
    t_regs();
    t_mirror();
    sum_chk(0, `UIF_B_HALT);
    sum_chk(1, `UIF_B_ABORT);
    sum_chk(2, `UIF_B_BUFF);
    ev_chk(0, `UIF_B_DEVICE_FRAME_START_SEEN, 4, 1'b0);
    ev_chk(2, `UIF_B_DEV_WAKE, 5, 1'b0);
    ev_chk(1, `UIF_B_HOST_SOF, 4, 1'b1);
    ev_chk(3, `UIF_B_HOST_WAKE, 5, 1'b1);
    chg_chk(0, `UIF_B_DEV_SLEEP, 6, 1'b0);
    chg_chk(1, `UIF_B_DEV_ATT, 7, 1'b0);
    chg_chk(2, `UIF_B_HOST_ATT, 8, 1'b1);
    t_trans();
    t_mask();
    t_lanes();
    results();
  end
endmodule // testbench
